// file: src/scsa_cfg.svh
// offsets, field positions, reset values and timing counts of the sequence assembler
`ifndef SCSA_CFG_SVH
`define SCSA_CFG_SVH

// register byte offsets on the apb bus
`define SCSA_CTRL_OFS 12'h000
`define SCSA_STAT_OFS 12'h004
`define SCSA_SEQ_OFS 12'h008

// control register fields
`define SCSA_CTRL_PL 0
`define SCSA_CTRL_HP 1
`define SCSA_CTRL_RDB 2
`define SCSA_CTRL_AB 3
`define SCSA_CTRL_SM_LO 4
`define SCSA_CTRL_SM_HI 8
`define SCSA_CTRL_RST 9'h000

// status register fields
`define SCSA_STAT_BC_LO 0
`define SCSA_STAT_BC_HI 2
`define SCSA_STAT_SYM_LO 4
`define SCSA_STAT_SYM_HI 11
`define SCSA_STAT_FRM_LO 16
`define SCSA_STAT_FRM_HI 31

// sequence layout: sync patterns and positions
`define SCSA_SYNC_HI 7'h32
`define SCSA_SYNC_LO 2'h3
`define SCSA_SEQ_BITS 32
`define SCSA_BLOCKS 8
`define SCSA_SYMS_PER_FRAME 256

`endif

// file: src/scsa_pkg.sv
// types shared by the sequence assembler files
package scsa_pkg;

   // service mode codes; codes 03..1F are reserved and pass through as raw bits
   typedef enum logic [4:0] {
      SM_NONE = 5'h00,
      SM_HYBRID_MODE = 5'h01,
      SM_ALL_DIGITAL_MODE = 5'h02
   } scsa_mode_t;

   // apb slave answer phase
   typedef enum logic [0:0] {
      APB_IDLE = 1'b0,
      APB_DONE = 1'b1
   } scsa_apb_t;

endpackage

// file: src/scsa_seq_build.sv
// one 32-bit system control data sequence, laid out with sync and parity bits
`timescale 1ns/1ps
`default_nettype none
`include "scsa_cfg.svh"

module scsa_seq_build (
   input wire logic power_level_flag,
   input wire logic high_power_ident_flag,
   input wire logic audio_bandwidth_flag,
   input wire logic reduced_bandwidth_flag,
   input wire logic [2:0] block_counter,
   input wire logic [4:0] service_mode_field,
   output logic [31:0] seq
);

   // reserved bits stay zero but still take part in their parity groups
   logic rsv4;
   logic rsv3;
   logic [2:0] rsv_lo;
   assign rsv4 = 1'b0;
   assign rsv3 = 1'b0;
   assign rsv_lo = 3'h0;

   // field layout from msb down
   always_comb
   begin
      seq = 32'h0000_0000;
      seq[31:25] = `SCSA_SYNC_HI;
      seq[24] = power_level_flag;
      seq[23] = power_level_flag;
      seq[22] = 1'b1;
      seq[21] = rsv4;
      seq[20] = high_power_ident_flag;
      seq[19] = audio_bandwidth_flag;
      seq[18] = ^{rsv4, high_power_ident_flag, audio_bandwidth_flag};
      seq[17] = 1'b0;
      seq[16] = reduced_bandwidth_flag;
      seq[15] = rsv3;
      seq[14:12] = block_counter;
      seq[11] = ^{reduced_bandwidth_flag, rsv3, block_counter};
      seq[10:9] = `SCSA_SYNC_LO;
      seq[8:6] = rsv_lo;
      seq[5:1] = service_mode_field;
      seq[0] = ^{rsv_lo, service_mode_field};
   end

endmodule // scsa_seq_build
`default_nettype wire

// file: src/scsa_top.sv
// system control data sequence assembler with apb control and per-frame vector output
`timescale 1ns/1ps
`default_nettype none
`include "scsa_cfg.svh"

module scsa_top (
   input wire logic CLK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0] PSTRB,
   output logic PREADY,
   output logic [31:0] PRDATA,
   output logic PSLVERR,
   input wire logic SYM_TICK,
   input wire logic FRAME_START,
   output logic [255:0] R_VEC,
   output logic R_VALID,
   output logic [2:0] BLOCK_COUNT,
   output logic BC_VALID
);

   // control register and timebase state
   logic [8:0] ctrl_q;
   logic [7:0] sym_cnt_q;
   logic [15:0] frames_q;
   logic [255:0] r_q;
   logic r_valid_q;
   logic [2:0] bc_q;
   logic bc_valid_q;
   scsa_pkg::scsa_apb_t apb_q;
   logic pready_q;
   logic [31:0] prdata_q;
   logic pslverr_q;

   // control fields as the configuration administrator set them
   logic pl_ctl;
   logic hp_ctl;
   logic rdb_ctl;
   logic ab_ctl;
   logic [4:0] sm_ctl;
   logic all_digital;
   logic pl_flag;
   logic hp_flag;
   logic ab_flag;
   logic rdb_flag;
   assign pl_ctl = ctrl_q[`SCSA_CTRL_PL];
   assign hp_ctl = ctrl_q[`SCSA_CTRL_HP];
   assign rdb_ctl = ctrl_q[`SCSA_CTRL_RDB];
   assign ab_ctl = ctrl_q[`SCSA_CTRL_AB];
   assign sm_ctl = ctrl_q[`SCSA_CTRL_SM_HI:`SCSA_CTRL_SM_LO];
   assign all_digital = (sm_ctl == scsa_pkg::SM_ALL_DIGITAL_MODE);

   // flag sanitising before the layout stage
   assign rdb_flag = rdb_ctl;
   assign pl_flag = pl_ctl & ~rdb_flag & ~all_digital;
   assign hp_flag = hp_ctl & ~rdb_flag;
   assign ab_flag = ab_ctl & ~all_digital;

   // one sequence per block, bit reversed into its slot of the vector
   logic [255:0] r_next;
   genvar gj;
   generate
      for (gj = 0; gj < `SCSA_BLOCKS; gj++)
      begin : g_blk
         logic [31:0] seq;
         scsa_seq_build u_seq (
            .power_level_flag(pl_flag),
            .high_power_ident_flag(hp_flag),
            .audio_bandwidth_flag(ab_flag),
            .reduced_bandwidth_flag(rdb_flag),
            .block_counter(3'(gj)),
            .service_mode_field(sm_ctl),
            .seq(seq)
         );
         for (genvar gi = 0; gi < `SCSA_SEQ_BITS; gi++)
         begin : g_bit
            assign r_next[32 * gj + gi] = seq[31 - gi];
         end
      end
   endgenerate

   // timebase: index of the symbol being sent on this tick
   logic [7:0] cur_idx;
   logic blk_start;
   logic frm_start;
   assign cur_idx = FRAME_START ? 8'h00 : sym_cnt_q;
   assign blk_start = SYM_TICK & (cur_idx[4:0] == 5'h00);
   assign frm_start = SYM_TICK & (cur_idx == 8'h00);

   // symbol counter wraps every frame; a frame start resyncs it
   always_ff @(posedge CLK)
   begin
      if (RST)
         sym_cnt_q <= 8'h00;
      else if (SYM_TICK)
         sym_cnt_q <= cur_idx + 8'h01;
      else if (FRAME_START)
         sym_cnt_q <= 8'h00;
   end

   // block count reported at each block's first symbol
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         bc_q <= 3'h0;
         bc_valid_q <= 1'b0;
      end
      else
      begin
         bc_valid_q <= blk_start;
         if (blk_start)
            bc_q <= cur_idx[7:5];
      end
   end

   // whole vector latched and strobed at each frame's first symbol
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         r_q <= 256'h0;
         r_valid_q <= 1'b0;
         frames_q <= 16'h0000;
      end
      else
      begin
         r_valid_q <= frm_start;
         if (frm_start)
         begin
            r_q <= r_next;
            frames_q <= frames_q + 16'h0001;
         end
      end
   end

   // apb decode; one wait state, write lands on the edge that sees pready
   logic acc;
   logic hit;
   assign acc = PSEL & PENABLE;
   assign hit = (PADDR == `SCSA_CTRL_OFS) | (PADDR == `SCSA_STAT_OFS) |
                (PADDR == `SCSA_SEQ_OFS);

   // sequence of the block last reported, bit order restored
   logic [31:0] cur_seq;
   always_comb
   begin
      cur_seq = 32'h0000_0000;
      for (int i = 0; i < `SCSA_SEQ_BITS; i++)
         cur_seq[31 - i] = r_q[{bc_q, 5'(i)}];
   end

   // read mux
   logic [31:0] rd_val;
   always_comb
   begin
      rd_val = 32'h0000_0000;
      if (PADDR == `SCSA_CTRL_OFS)
         rd_val[8:0] = ctrl_q;
      else if (PADDR == `SCSA_STAT_OFS)
      begin
         rd_val[`SCSA_STAT_BC_HI:`SCSA_STAT_BC_LO] = bc_q;
         rd_val[`SCSA_STAT_SYM_HI:`SCSA_STAT_SYM_LO] = sym_cnt_q;
         rd_val[`SCSA_STAT_FRM_HI:`SCSA_STAT_FRM_LO] = frames_q;
      end
      else if (PADDR == `SCSA_SEQ_OFS)
         rd_val = cur_seq;
   end

   // answer phase state
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         apb_q <= scsa_pkg::APB_IDLE;
         pready_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end
      else
      begin
         unique case (apb_q)
            scsa_pkg::APB_IDLE:
            begin
               if (acc)
               begin
                  apb_q <= scsa_pkg::APB_DONE;
                  pready_q <= 1'b1;
                  prdata_q <= PWRITE ? 32'h0000_0000 : rd_val;
                  pslverr_q <= ~hit;
               end
            end
            scsa_pkg::APB_DONE:
            begin
               apb_q <= scsa_pkg::APB_IDLE;
               pready_q <= 1'b0;
               prdata_q <= 32'h0000_0000;
               pslverr_q <= 1'b0;
            end
         endcase
      end
   end

   // control register write, byte lanes honoured
   always_ff @(posedge CLK)
   begin
      if (RST)
         ctrl_q <= `SCSA_CTRL_RST;
      else if (acc & pready_q & PWRITE & (PADDR == `SCSA_CTRL_OFS))
      begin
         if (PSTRB[0])
            ctrl_q[7:0] <= PWDATA[7:0];
         if (PSTRB[1])
            ctrl_q[8] <= PWDATA[8];
      end
   end

   // outputs straight from flops
   assign PREADY = pready_q;
   assign PRDATA = prdata_q;
   assign PSLVERR = pslverr_q;
   assign R_VEC = r_q;
   assign R_VALID = r_valid_q;
   assign BLOCK_COUNT = bc_q;
   assign BC_VALID = bc_valid_q;

   // checker helpers: first and last sequence back in natural bit order
   logic [31:0] chk_s0;
   logic [31:0] chk_s7;
   logic seen_bc_q;
   logic [2:0] prev_bc_q;
   always_comb
   begin
      chk_s0 = 32'h0000_0000;
      chk_s7 = 32'h0000_0000;
      for (int i = 0; i < 32; i++)
      begin
         chk_s0[31 - i] = r_q[i];
         chk_s7[31 - i] = r_q[224 + i];
      end
   end

   // remembers whether a count was reported and which
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         seen_bc_q <= 1'b0;
         prev_bc_q <= 3'h0;
      end
      else if (bc_valid_q)
      begin
         seen_bc_q <= 1'b1;
         prev_bc_q <= bc_q;
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   chk_sync_bits: assert property (R_VALID |-> chk_s7[31:25] == 7'h32 && chk_s7[22]
      && !chk_s7[17] && chk_s7[10:9] == 2'h3)
      else $error("sync bits wrong");
   chk_parity_even: assert property (R_VALID |-> !(^chk_s0[24:23]) && !(^chk_s0[21:18])
      && !(^chk_s0[16:11]) && !(^chk_s0[8:0]))
      else $error("parity not even");
   chk_pl_forced: assert property (R_VALID && (chk_s0[16] || chk_s0[5:1] == 5'h02)
      |-> !chk_s0[24])
      else $error("power level flag not forced low");
   chk_pl_follow: assert property (R_VALID && !chk_s0[16] && chk_s0[5:1] != 5'h02
      |-> chk_s0[24] == $past(ctrl_q[0]))
      else $error("power level flag not following control");
   chk_hp_forced: assert property (R_VALID |-> chk_s0[20] ==
      ($past(ctrl_q[1]) && !$past(ctrl_q[2])))
      else $error("high-power flag wrong");
   chk_ab_digital: assert property (R_VALID && chk_s0[5:1] == 5'h02 |-> !chk_s7[19])
      else $error("audio flag set in all-digital mode");
   chk_rdb_smi: assert property (R_VALID |-> chk_s0[16] == $past(ctrl_q[2])
      && chk_s7[5:1] == $past(ctrl_q[8:4]))
      else $error("reduced bandwidth or mode field mismatch");
   chk_bc_slots: assert property (R_VALID |-> chk_s0[14:12] == 3'h0
      && chk_s7[14:12] == 3'h7 && r_q[83:81] == 3'h2)
      else $error("block counter slots wrong");
   chk_bc_first: assert property (BC_VALID && !seen_bc_q |-> BLOCK_COUNT == 3'h0)
      else $error("first block count not zero");
   chk_bc_step: assert property (BC_VALID && seen_bc_q && BLOCK_COUNT != 3'h0
      |-> BLOCK_COUNT == prev_bc_q + 3'h1)
      else $error("block count skipped");
   chk_frame_pulse: assert property (R_VALID |-> BC_VALID && BLOCK_COUNT == 3'h0)
      else $error("frame strobe off its block");
   chk_apb_answer: assert property (PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
      else $error("apb answer not one wait state");
   chk_ab_follow: assert property (R_VALID && chk_s0[5:1] != 5'h02
      |-> chk_s0[19] == $past(ctrl_q[3]))
      else $error("audio flag not following control");
   chk_last_parity: assert property (R_VALID |-> !(^chk_s7[24:23]) && !(^chk_s7[21:18])
      && !(^chk_s7[16:11]) && !(^chk_s7[8:0]))
      else $error("parity of last block not even");
   // outputs hold between their strobes
   chk_vec_hold: assert property (!R_VALID |-> $stable(R_VEC))
      else $error("frame vector changed between frames");
   chk_count_hold: assert property (!BC_VALID |-> $stable(BLOCK_COUNT))
      else $error("block count changed between blocks");
   // answer shape on the register bus
   chk_err_answer: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0000_0000)
      else $error("error answer malformed");
   chk_ready_pulse: assert property (PREADY |=> !PREADY)
      else $error("ready held over two cycles");

   cov_frame: cover property (R_VALID);
   cov_reduced: cover property (R_VALID && chk_s0[16]);
   cov_digital: cover property (R_VALID && chk_s0[5:1] == 5'h02);
   cov_write: cover property (PSEL && PENABLE && PREADY && PWRITE);
   cov_resync: cover property (SYM_TICK && FRAME_START && sym_cnt_q != 8'h00);

endmodule // scsa_top
`default_nettype wire

// file: dv/scsa_admin_model.sv
// far-side model: symbol timebase with frame-start marks and random spacing
`timescale 1ns/1ps
`default_nettype none

module scsa_admin_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic go,
   input wire logic [8:0] n_ticks,
   input wire logic with_fs,
   output logic sym_tick,
   output logic frame_start,
   output logic busy
);
   integer seed = 32'hFE9D;
   int left;
   int gap;
   logic first;
   logic tick_n;
   logic mark_n;

   // one burst of symbol ticks per go pulse, gaps of 0..3 idle cycles
   always @(posedge clk)
   begin
      tick_n = 1'h0;
      mark_n = 1'h0;
      if (rst)
      begin
         busy <= 1'h0;
         left = 0;
         gap = 0;
      end
      else if (go && !busy)
      begin
         left = n_ticks;
         busy <= 1'h1;
         first = with_fs;
         gap = 0;
      end
      else if (left > 0)
      begin
         if (gap > 0)
            gap--;
         else
         begin
            tick_n = 1'h1;
            mark_n = first; // resync mark rides on the first tick only
            first = 1'h0;
            left--;
            gap = $random(seed) & 3;
         end
      end
      else
         busy <= 1'h0;
      sym_tick <= tick_n;
      frame_start <= mark_n;
   end
endmodule // scsa_admin_model

`default_nettype wire

// file: dv/system_control_sequence_assembler_test.sv
// self-checking bench for the sequence assembler
`timescale 1ns/1ps
`default_nettype none
`include "scsa_cfg.svh"

module system_control_sequence_assembler_test;
   logic clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic go = 1'h0, fs_en = 1'h0, sym_tick, frame_start, busy;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] pstrb = 4'h0;
   logic [8:0] nt = 9'h000, ctrl_m = 9'h000, c;
   logic pready, pslverr, r_valid, bc_valid, er, ebv = 1'h0, erv = 1'h0;
   logic [255:0] r_vec, evec;
   logic [2:0] block_count, ebc;
   logic [8:0] tbl [6] = '{9'h00B, 9'h01B, 9'h02B, 9'h01F, 9'h1F3, 9'h03A};
   integer seed = 32'hFE9D;
   int n_fail = 0, samples_checked = 0, cyc = 0, cnt = 0, idx, nfrm = 0;

   always #5 clk = ~clk;

   scsa_top DUT (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PREADY(pready), .PRDATA(prdata),
      .PSLVERR(pslverr), .SYM_TICK(sym_tick), .FRAME_START(frame_start), .R_VEC(r_vec),
      .R_VALID(r_valid), .BLOCK_COUNT(block_count), .BC_VALID(bc_valid));

   scsa_admin_model admin (.clk(clk), .rst(rst), .go(go), .n_ticks(nt), .with_fs(fs_en),
      .sym_tick(sym_tick), .frame_start(frame_start), .busy(busy));

   // expected sequence of block j for control word c
   function automatic logic [31:0] exp_seq(input logic [8:0] c, input int j);
      logic plf, hpf, abf;
      plf = c[0] & ~c[2] & (c[8:4] != 5'h02);
      hpf = c[1] & ~c[2];
      abf = c[3] & (c[8:4] != 5'h02);
      return {7'h32, plf, plf, 1'h1, 1'h0, hpf, abf, hpf ^ abf, 1'h0, c[2], 1'h0, 3'(j),
         ^{c[2], 3'(j)}, 2'h3, 3'h0, c[8:4], ^c[8:4]};
   endfunction

   // whole frame vector, sequence bit 31 first
   function automatic logic [255:0] mkvec(input logic [8:0] c);
      logic [255:0] v;
      logic [31:0] s;
      for (int j = 0; j < 8; j++)
      begin
         s = exp_seq(c, j);
         for (int i = 0; i < 32; i++)
            v[32 * j + i] = s[31 - i];
      end
      return v;
   endfunction

   task automatic chk(input string nm, input logic [255:0] seen, input logic [255:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [31:0] rdata, output logic err);
      @(posedge clk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= w ? s : 4'h0; // strobes stay low on reads
      @(posedge clk);
      penable <= 1'h1;
      do
      begin
         @(posedge clk);
      end
      while (pready !== 1'h1);
      rdata = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (w && a == `SCSA_CTRL_OFS && err === 1'h0)
      begin
         if (s[0])
            ctrl_m[7:0] = d[7:0];
         if (s[1])
            ctrl_m[8] = d[8];
      end
   endtask

   // run n symbol ticks through the far-side model and let results settle
   task automatic frame(input int n, input logic f);
      @(posedge clk);
      nt <= 9'(n);
      fs_en <= f;
      go <= 1'h1;
      @(posedge clk);
      go <= 1'h0;
      @(posedge clk);
      while (busy === 1'h1)
      begin
         @(posedge clk);
      end
      repeat (2) @(posedge clk);
   endtask

   // reference model of the symbol link, compared every cycle
   always @(posedge clk)
   begin
      if (rst)
         cnt = 0;
      else
      begin
         chk("bc_valid", bc_valid, ebv);
         if (ebv) chk("block_count", block_count, ebc);
         chk("r_valid", r_valid, erv);
         if (erv) chk("r_vec", r_vec, evec);
         ebv = 1'h0;
         erv = 1'h0;
         if (sym_tick)
         begin
            idx = frame_start ? 0 : cnt;
            cnt = (idx + 1) % 256;
            ebv = (idx % 32 == 0);
            ebc = 3'(idx / 32);
            erv = (idx == 0);
            if (erv)
               nfrm++;
            evec = mkvec(ctrl_m);
         end
      end
   end

   // hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cyc > 50000)
      begin
         n_fail++;
         print_verdict();
      end
   end

   // main sequence
   initial
   begin
      repeat (5) @(posedge clk);
      rst <= 1'h0;
      apb(1'h0, `SCSA_CTRL_OFS, 32'h0, 4'hF, rd, er);
      chk("ctrl_reset", rd, 256'h0);
      apb(1'h0, 12'h00C, 32'h0, 4'hF, rd, er);
      chk("unmapped_err", {er, rd}, 256'h1_0000_0000);
      for (int i = 0; i < 10; i++)
      begin
         c = (i < 6) ? tbl[i] : 9'($random(seed));
         apb(1'h1, `SCSA_CTRL_OFS, 32'(c), (i < 6) ? 4'hF : 4'($random(seed)), rd, er);
         apb(1'h1, `SCSA_STAT_OFS, $random(seed), 4'hF, rd, er);
         apb(1'h0, `SCSA_CTRL_OFS, 32'h0, 4'hF, rd, er);
         chk("ctrl_read", rd, 256'(ctrl_m));
         frame(256, 1'(i % 2));
         apb(1'h0, `SCSA_SEQ_OFS, 32'h0, 4'hF, rd, er);
         chk("seq_read", rd, 256'(exp_seq(ctrl_m, 7)));
         apb(1'h0, `SCSA_STAT_OFS, 32'h0, 4'hF, rd, er);
         chk("stat_read", rd, {224'h0, 16'(nfrm), 4'h0, 8'(cnt), 1'h0, 3'h7});
      end
      frame(40, 1'h0);
      frame(256, 1'h1);
      print_verdict();
   end
endmodule // system_control_sequence_assembler_test

`default_nettype wire
